/* rtl/ceau_pkg.sv */
// Package of constants and types for the effective address unit
package ceau_pkg;
  localparam int ADDR_W = 16;
  localparam int REG_NUM = 8;
  localparam int REG_SEL_W = 3;
  localparam logic [2:0] SP_REG = 3'h7;
  localparam logic [7:0] ABS8_HIGH = 8'hFF;
  localparam logic [7:0] IND8_HIGH = 8'h00;
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;
  localparam logic [15:0] WORD_ALIGN_MASK = 16'hFFFE;
  localparam int BITNO_W = 3;
  typedef enum logic [3:0] {
    CEAU_AM_REG_DIRECT,
    CEAU_AM_REG_INDIRECT,
    CEAU_AM_DISP16,
    CEAU_AM_POST_INC,
    CEAU_AM_PRE_DEC,
    CEAU_AM_ABS8,
    CEAU_AM_ABS16,
    CEAU_AM_IMM8,
    CEAU_AM_IMM16,
    CEAU_AM_PC_REL,
    CEAU_AM_MEM_IND
  } ceau_mode_t;
  typedef enum logic [4:0] {
    CEAU_OP_BYTE_MOVE,
    CEAU_OP_WORD_MOVE,
    CEAU_OP_PUSH,
    CEAU_OP_POP,
    CEAU_OP_WORD_ADD,
    CEAU_OP_WORD_SUB,
    CEAU_OP_WORD_COMPARE,
    CEAU_OP_ADD_SMALL_CONST,
    CEAU_OP_SUB_SMALL_CONST,
    CEAU_OP_UNSIGNED_MULTIPLY,
    CEAU_OP_UNSIGNED_DIVIDE,
    CEAU_OP_BYTE_ADD,
    CEAU_OP_ADD_WITH_CARRY,
    CEAU_OP_SUBTRACT_WITH_BORROW,
    CEAU_OP_BYTE_COMPARE,
    CEAU_OP_LOGIC_IMM,
    CEAU_OP_ALU_OTHER,
    CEAU_OP_BIT_SET,
    CEAU_OP_BIT_CLEAR,
    CEAU_OP_BIT_INVERT,
    CEAU_OP_BIT_TEST,
    CEAU_OP_BIT_OTHER,
    CEAU_OP_JUMP,
    CEAU_OP_SUBROUTINE_CALL,
    CEAU_OP_COND_BRANCH,
    CEAU_OP_BRANCH_TO_SUBROUTINE
  } ceau_op_t;
endpackage : ceau_pkg

/* rtl/ceau_reg_if.sv */
// Interface between the address unit and its register file
`timescale 1ns/1ps
interface ceau_reg_if;
  logic [2:0] rd_sel;
  logic [15:0] rd_data;
  logic wr_en;
  logic [2:0] wr_sel;
  logic [15:0] wr_data;
  modport owner (input rd_sel, input wr_en, input wr_sel, input wr_data, output rd_data);
  modport user (output rd_sel, output wr_en, output wr_sel, output wr_data, input rd_data);
endinterface : ceau_reg_if

/* rtl/ceau_regfile.sv */
// Register file holding the eight 16-bit general registers
`timescale 1ns/1ps
module ceau_regfile #(
  parameter int NUM = 8
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Access port
  ceau_reg_if.owner rf
);
  logic [15:0] regs [NUM];
  logic [15:0] rd_q;

  initial begin
    if (NUM != 8) begin
      $error("ceau_regfile: NUM must be 8");
    end
  end

  assign rf.rd_data = rd_q;

  // Read data are registered; the reset value is zero for determinism only
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rd_q <= 16'h0000;
    end else begin
      rd_q <= regs[rf.rd_sel];
    end
  end

  generate
    for (genvar i = 0; i < NUM; i++) begin : g_reg
      always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
          regs[i] <= 16'h0000;
        end else if (rf.wr_en && rf.wr_sel == 3'(i)) begin
          regs[i] <= rf.wr_data;
        end
      end
    end
  endgenerate
endmodule : ceau_regfile

/* rtl/ceau_top.sv */
// Effective address generation and addressing-mode check for the CPU core
// Notes on behaviour
// - Register direct takes operand from selected 8- or 16-bit register.
// - Only word move/add/sub/compare, push/pop, small-const, multiply, divide use 16-bit.
// - Register indirect uses selected 16-bit register as address.
// - Displacement: bytes 3-4 added to register; moves only.
// - Post-increment: access at register, then add 1 byte or 2 word.
// - Pre-decrement: subtract 1 or 2 first, use and keep result.
// - Post-increment for loads, pre-decrement for stores.
// - 8-bit absolute forces upper byte to ones.
// - Abs8 only byte move and bit ops; abs16 moves, jump, call.
// - Imm8 from byte 2, imm16 from bytes 3-4, word move only.
// - Small-constant add and subtract imply 1 or 2.
// - Bit number is 3 bits from byte 2 or byte 4.
// - PC-relative sign-extends byte 2 and adds to PC.
// - Memory indirect reads word at zero-page byte address as target.
// - Odd branch target or word-move address has bit 0 cleared.
// - ALU ops register direct only; some byte ops allow immediate.
// - Data transfer allows all modes but PC-relative and memory indirect.
// - Bit ops: direct, indirect or abs8; bit number immediate or register.
// - Memory indirect for jump and call; PC-relative for branches.
// - Push is word store pre-decrement, pop word load post-increment of SP.
// - Register 7 is the implicit stack pointer.
`timescale 1ns/1ps
module ceau_top
  import ceau_pkg::*;
#(
  parameter int AW = 16
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Decoded instruction from the decoder
  input wire logic req_valid_i,
  input wire ceau_pkg::ceau_op_t op_i,
  input wire ceau_pkg::ceau_mode_t mode_i,
  input wire logic [2:0] reg_sel_i,
  input wire logic reg_low_byte_i,
  input wire logic store_i,
  input wire logic [7:0] ibyte2_i,
  input wire logic [7:0] ibyte4_i,
  input wire logic [15:0] iword2_i,
  input wire logic bitno_from_reg_i,
  input wire logic bitno_in_byte4_i,
  input wire logic [2:0] bitno_reg_sel_i,
  input wire logic small_const_two_i,
  input wire logic [15:0] pc_i,
  // Memory word read for memory indirect
  input wire logic [15:0] mem_rdata_i,
  input wire logic mem_ack_i,
  // Register write from the execute stage
  input wire logic exe_wr_en_i,
  input wire logic [2:0] exe_wr_sel_i,
  input wire logic [15:0] exe_wr_data_i,
  // Results
  output logic done_o,
  output logic illegal_o,
  output logic [15:0] ea_o,
  output logic ea_is_mem_o,
  output logic ea_is_branch_o,
  output logic word_op_o,
  output logic [15:0] operand_o,
  output logic [2:0] bitno_o,
  output logic busy_o,
  // Memory request for memory indirect
  output logic mem_req_o,
  output logic [15:0] mem_addr_o
);
  import ceau_pkg::*;

  if (AW != ADDR_W) begin : g_aw_check
    $error("ceau_top: AW must be 16");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_READ, ST_CALC, ST_BITREG, ST_MEMIND, ST_DONE} ceau_state_t;

  ceau_state_t state, next_state;

  ceau_op_t op_q;
  ceau_mode_t mode_q;
  logic [2:0] sel_q, bit_sel_q;
  logic low_q, store_q, bit_reg_q, bit_b4_q, two_q;
  logic [7:0] b2_q, b4_q;
  logic [15:0] w2_q, pc_q, base_q;

  ceau_reg_if rf ();

  ceau_regfile #(.NUM(REG_NUM)) u_regfile (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .rf(rf)
  );

  // ----------------------------------------------------------------
  // Mode legality
  // ----------------------------------------------------------------
  wire is_move = (op_q == CEAU_OP_BYTE_MOVE) || (op_q == CEAU_OP_WORD_MOVE);
  wire is_stack = (op_q == CEAU_OP_PUSH) || (op_q == CEAU_OP_POP);
  wire is_bit_reg_ok = (op_q == CEAU_OP_BIT_SET) || (op_q == CEAU_OP_BIT_CLEAR) ||
                       (op_q == CEAU_OP_BIT_INVERT) || (op_q == CEAU_OP_BIT_TEST);
  wire is_bit = is_bit_reg_ok || (op_q == CEAU_OP_BIT_OTHER);
  wire is_jump_call = (op_q == CEAU_OP_JUMP) || (op_q == CEAU_OP_SUBROUTINE_CALL);
  wire is_rel_branch = (op_q == CEAU_OP_COND_BRANCH) ||
                       (op_q == CEAU_OP_BRANCH_TO_SUBROUTINE);
  wire is_small_const = (op_q == CEAU_OP_ADD_SMALL_CONST) ||
                        (op_q == CEAU_OP_SUB_SMALL_CONST);
  wire is_alu_imm = (op_q == CEAU_OP_BYTE_ADD) || (op_q == CEAU_OP_ADD_WITH_CARRY) ||
                    (op_q == CEAU_OP_SUBTRACT_WITH_BORROW) ||
                    (op_q == CEAU_OP_BYTE_COMPARE) || (op_q == CEAU_OP_LOGIC_IMM);
  // Word width for register operands and memory moves
  wire word_op = (op_q == CEAU_OP_WORD_MOVE) || is_stack || (op_q == CEAU_OP_WORD_ADD) ||
                 (op_q == CEAU_OP_WORD_SUB) || (op_q == CEAU_OP_WORD_COMPARE) ||
                 is_small_const || (op_q == CEAU_OP_UNSIGNED_MULTIPLY) ||
                 (op_q == CEAU_OP_UNSIGNED_DIVIDE);

  // Post-increment only on loads, pre-decrement only on stores
  wire legal_incdec = is_move && ((mode_q == CEAU_AM_POST_INC && !store_q) ||
                      (mode_q == CEAU_AM_PRE_DEC && store_q));
  wire legal_move = (mode_q == CEAU_AM_REG_DIRECT) || (mode_q == CEAU_AM_REG_INDIRECT) ||
                    (mode_q == CEAU_AM_DISP16) || legal_incdec ||
                    (mode_q == CEAU_AM_ABS8 && op_q == CEAU_OP_BYTE_MOVE) ||
                    (mode_q == CEAU_AM_ABS16) || (mode_q == CEAU_AM_IMM8) ||
                    (mode_q == CEAU_AM_IMM16 && op_q == CEAU_OP_WORD_MOVE);
  wire legal_stack = (op_q == CEAU_OP_PUSH) ? (mode_q == CEAU_AM_PRE_DEC) :
                     (mode_q == CEAU_AM_POST_INC);
  wire legal_bit = (mode_q == CEAU_AM_REG_DIRECT) || (mode_q == CEAU_AM_REG_INDIRECT) ||
                   (mode_q == CEAU_AM_ABS8);
  wire legal_bitno = !bit_reg_q || is_bit_reg_ok;
  wire legal_jump = (mode_q == CEAU_AM_REG_INDIRECT) || (mode_q == CEAU_AM_ABS16) ||
                    (mode_q == CEAU_AM_MEM_IND);
  wire legal_alu = (mode_q == CEAU_AM_REG_DIRECT) ||
                   (mode_q == CEAU_AM_IMM8 && is_alu_imm);

  logic legal;
  always_comb begin
    legal = 1'b0;
    if (is_move) begin
      legal = legal_move;
    end else if (is_stack) begin
      legal = legal_stack;
    end else if (is_bit) begin
      legal = legal_bit && legal_bitno;
    end else if (is_jump_call) begin
      legal = legal_jump;
    end else if (is_rel_branch) begin
      legal = (mode_q == CEAU_AM_PC_REL);
    end else begin
      legal = legal_alu;
    end
  end

  // ----------------------------------------------------------------
  // Address arithmetic, all 16 bits wide so sums wrap
  // ----------------------------------------------------------------
  wire [15:0] step = word_op ? STEP_WORD : STEP_BYTE;
  wire [15:0] disp_sum = base_q + w2_q;
  wire [15:0] dec_val = base_q - step;
  wire [15:0] inc_val = base_q + step;
  wire [15:0] rel_ext = {{8{b2_q[7]}}, b2_q};
  // Odd displacements are not screened; software keeps them even
  wire [15:0] rel_sum = pc_q + rel_ext;
  wire [15:0] abs8_addr = {ABS8_HIGH, b2_q};
  wire [15:0] ind8_addr = {IND8_HIGH, b2_q};
  wire [7:0] reg_byte = low_q ? base_q[7:0] : base_q[15:8];
  wire [15:0] small_const = two_q ? STEP_WORD : STEP_BYTE;

  logic [15:0] raw_ea, next_operand;
  logic is_mem, is_branch;
  always_comb begin
    raw_ea = 16'h0000;
    is_mem = 1'b0;
    is_branch = 1'b0;
    next_operand = 16'h0000;
    case (mode_q)
      CEAU_AM_REG_DIRECT: begin
        next_operand = word_op ? base_q : {8'h00, reg_byte};
        if (is_small_const) begin
          next_operand = small_const;
        end
      end
      CEAU_AM_REG_INDIRECT, CEAU_AM_POST_INC: begin
        raw_ea = base_q;
        is_mem = !is_jump_call;
        is_branch = is_jump_call;
      end
      CEAU_AM_DISP16: begin
        raw_ea = disp_sum;
        is_mem = 1'b1;
      end
      CEAU_AM_PRE_DEC: begin
        raw_ea = dec_val;
        is_mem = 1'b1;
      end
      CEAU_AM_ABS8: begin
        raw_ea = abs8_addr;
        is_mem = 1'b1;
      end
      CEAU_AM_ABS16: begin
        raw_ea = w2_q;
        is_mem = !is_jump_call;
        is_branch = is_jump_call;
      end
      CEAU_AM_IMM8: begin
        next_operand = {8'h00, b2_q};
      end
      CEAU_AM_IMM16: begin
        next_operand = w2_q;
      end
      CEAU_AM_PC_REL: begin
        raw_ea = rel_sum;
        is_branch = 1'b1;
      end
      CEAU_AM_MEM_IND: begin
        raw_ea = mem_rdata_i;
        is_branch = 1'b1;
      end
      default: begin
        raw_ea = 16'h0000;
      end
    endcase
  end

  // Word accesses and branch targets drop bit 0
  wire align = is_branch || (is_mem && word_op);
  wire [15:0] final_ea = align ? (raw_ea & WORD_ALIGN_MASK) : raw_ea;
  wire upd_base = legal && ((mode_q == CEAU_AM_POST_INC) || (mode_q == CEAU_AM_PRE_DEC));
  wire [15:0] upd_val = (mode_q == CEAU_AM_POST_INC) ? inc_val : dec_val;
  wire [2:0] bitno_imm = bit_b4_q ? b4_q[2:0] : b2_q[2:0];
  wire req_stack = (op_i == CEAU_OP_PUSH) || (op_i == CEAU_OP_POP);
  wire [2:0] stack_sel = req_stack ? SP_REG : reg_sel_i;

  // ----------------------------------------------------------------
  // Register file access
  // ----------------------------------------------------------------
  wire calc_write = (state == ST_CALC) && upd_base;
  assign rf.rd_sel = (state == ST_CALC) ? bit_sel_q : (state == ST_IDLE) ? stack_sel : sel_q;
  assign rf.wr_en = calc_write || (exe_wr_en_i && !calc_write);
  assign rf.wr_sel = calc_write ? sel_q : exe_wr_sel_i;
  assign rf.wr_data = calc_write ? upd_val : exe_wr_data_i;

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  wire need_bitreg = is_bit && bit_reg_q && legal;
  wire need_memind = (mode_q == CEAU_AM_MEM_IND) && legal;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (req_valid_i) begin
          next_state = ST_READ;
        end
      end
      ST_READ: begin
        next_state = ST_CALC;
      end
      ST_CALC: begin
        if (need_bitreg) begin
          next_state = ST_BITREG;
        end else if (need_memind) begin
          next_state = ST_MEMIND;
        end else begin
          next_state = ST_DONE;
        end
      end
      ST_BITREG: begin
        next_state = ST_DONE;
      end
      ST_MEMIND: begin
        if (mem_ack_i) begin
          next_state = ST_DONE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  assign busy_o = (state != ST_IDLE);
  assign mem_req_o = (state == ST_MEMIND);
  assign mem_addr_o = ind8_addr & WORD_ALIGN_MASK;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Request capture; the stack forms force the stack pointer
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      op_q <= CEAU_OP_BYTE_MOVE;
      mode_q <= CEAU_AM_REG_DIRECT;
      sel_q <= 3'h0;
      low_q <= 1'b0;
      store_q <= 1'b0;
      b2_q <= 8'h00;
      b4_q <= 8'h00;
      w2_q <= 16'h0000;
      bit_reg_q <= 1'b0;
      bit_b4_q <= 1'b0;
      bit_sel_q <= 3'h0;
      two_q <= 1'b0;
      pc_q <= 16'h0000;
    end else if (state == ST_IDLE && req_valid_i) begin
      op_q <= op_i;
      mode_q <= mode_i;
      sel_q <= stack_sel;
      low_q <= reg_low_byte_i;
      store_q <= (op_i == CEAU_OP_PUSH) ? 1'b1 : (op_i == CEAU_OP_POP) ? 1'b0 : store_i;
      b2_q <= ibyte2_i;
      b4_q <= ibyte4_i;
      w2_q <= iword2_i;
      bit_reg_q <= bitno_from_reg_i;
      bit_b4_q <= bitno_in_byte4_i;
      bit_sel_q <= bitno_reg_sel_i;
      two_q <= small_const_two_i;
      pc_q <= pc_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      base_q <= 16'h0000;
    end else if (state == ST_READ) begin
      base_q <= rf.rd_data;
    end
  end

  // ----------------------------------------------------------------
  // Result registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      done_o <= 1'b0;
      illegal_o <= 1'b0;
      ea_o <= 16'h0000;
      ea_is_mem_o <= 1'b0;
      ea_is_branch_o <= 1'b0;
      word_op_o <= 1'b0;
      operand_o <= 16'h0000;
      bitno_o <= 3'h0;
    end else begin
      done_o <= (next_state == ST_DONE) && (state != ST_DONE);
      if (state == ST_CALC) begin
        illegal_o <= !legal;
        ea_o <= final_ea;
        ea_is_mem_o <= is_mem && legal;
        ea_is_branch_o <= is_branch && legal;
        word_op_o <= word_op;
        operand_o <= next_operand;
        bitno_o <= bitno_imm;
      end else if (state == ST_BITREG) begin
        bitno_o <= rf.rd_data[BITNO_W-1:0];
      end else if (state == ST_MEMIND && mem_ack_i) begin
        ea_o <= final_ea;
      end
    end
  end
endmodule : ceau_top

/* tb/ceau_top_checker.sv */
// Port-level assertion checker for the effective address unit
`timescale 1ns/1ps
module ceau_top_checker
  import ceau_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Request side
  input wire logic req_valid_i,
  input wire ceau_pkg::ceau_mode_t mode_i,
  input wire logic [7:0] ibyte2_i,
  input wire logic [15:0] iword2_i,
  input wire logic [15:0] pc_i,
  input wire logic mem_ack_i,
  input wire logic [15:0] mem_rdata_i,
  // Results
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic illegal_o,
  input wire logic [15:0] ea_o,
  input wire logic ea_is_mem_o,
  input wire logic ea_is_branch_o,
  input wire logic word_op_o,
  input wire logic [15:0] operand_o,
  input wire logic mem_req_o,
  input wire logic [15:0] mem_addr_o
);
  ceau_mode_t md;
  logic [7:0] b2;
  logic [15:0] iw;
  logic [15:0] pcq;
  logic ok;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  // The request fields are only valid at the take edge, so keep them
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      md <= CEAU_AM_REG_DIRECT;
      b2 <= 8'h00;
      iw <= 16'h0000;
      pcq <= 16'h0000;
    end else if (req_valid_i && !busy_o) begin
      md <= mode_i;
      b2 <= ibyte2_i;
      iw <= iword2_i;
      pcq <= pc_i;
    end
  end
  assign ok = done_o && !illegal_o;

  a_abs8_high: assert property (ok && md == CEAU_AM_ABS8 |-> ea_o == {8'hFF, b2})
    else $error("short absolute address not in top page");
  a_pcrel_target: assert property (ok && md == CEAU_AM_PC_REL |->
    ea_o == ((pcq + {{8{b2[7]}}, b2}) & 16'hFFFE))
    else $error("relative branch target wrong");
  a_memind_page: assert property (mem_req_o |-> mem_addr_o == ({8'h00, b2} & 16'hFFFE))
    else $error("indirect pointer address outside page zero");
  a_memind_result: assert property (mem_req_o && mem_ack_i |=>
    done_o && ea_o == ($past(mem_rdata_i) & 16'hFFFE))
    else $error("indirect target not taken from memory word");
  a_req_held: assert property (mem_req_o && !mem_ack_i |=> mem_req_o)
    else $error("memory request dropped before acknowledge");
  a_word_even: assert property (done_o && (ea_is_branch_o || word_op_o && ea_is_mem_o)
    |-> !ea_o[0])
    else $error("odd word or branch address");
  a_illegal_quiet: assert property (done_o && illegal_o |-> !ea_is_mem_o && !ea_is_branch_o)
    else $error("refused mode still flagged an access");
  a_imm16_value: assert property (ok && md == CEAU_AM_IMM16 |-> operand_o == iw)
    else $error("long immediate not from bytes three and four");
  a_memind_branch: assert property (ok && md == CEAU_AM_MEM_IND |-> ea_is_branch_o)
    else $error("indirect jump not marked as branch");
endmodule : ceau_top_checker

bind ceau_top ceau_top_checker i_chk (.sys_clk_i, .rst_i, .req_valid_i, .mode_i, .ibyte2_i,
  .iword2_i, .pc_i, .mem_ack_i, .mem_rdata_i, .busy_o, .done_o, .illegal_o, .ea_o,
  .ea_is_mem_o, .ea_is_branch_o, .word_op_o, .operand_o, .mem_req_o, .mem_addr_o);

/* tb/ceau_mem_model.sv */
// Memory model answering the unit's memory-indirect word reads
`timescale 1ns/1ps
module ceau_mem_model (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Answer delay in cycles
  input wire logic [3:0] delay_i,
  // Word read port
  input wire logic mem_req_i,
  input wire logic [15:0] mem_addr_i,
  output logic mem_ack_o,
  output logic [15:0] mem_rdata_o
);
  logic [3:0] wait_cnt;
  logic hit;
  logic [15:0] word;
  // Stored words are odd on purpose, so a missing alignment shows
  assign word = {~mem_addr_i[7:0], mem_addr_i[7:0]} | 16'h0001;
  assign hit = mem_req_i && !mem_ack_o && wait_cnt == delay_i;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !mem_req_i || mem_ack_o) begin
      wait_cnt <= 4'h0;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
  // Data is valid only with the acknowledge; it toggles otherwise
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      mem_ack_o <= 1'b0;
      mem_rdata_o <= 16'h5A5A;
    end else begin
      mem_ack_o <= hit;
      mem_rdata_o <= hit ? word : ~mem_rdata_o;
    end
  end
endmodule : ceau_mem_model

/* tb/cpu_effective_address_unit_test.sv */
// Self-checking bench for the effective address unit
`timescale 1ns/1ps
module cpu_effective_address_unit_test;
  import ceau_pkg::*;
  localparam ceau_op_t BM = CEAU_OP_BYTE_MOVE;
  localparam ceau_op_t WM = CEAU_OP_WORD_MOVE;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req = 1'b0, st = 1'b0, wen = 1'b0;
  logic [3:0] fl = 4'h0, mdelay = 4'h0;
  ceau_op_t op = BM;
  ceau_mode_t mode = CEAU_AM_REG_DIRECT;
  logic [2:0] rs = 3'h0, wsel = 3'h0;
  logic [7:0] b2 = 8'h00;
  logic [15:0] w2 = 16'h0000, wdata = 16'h0000;
  logic done, ill, is_mem, is_br, wop, busy, mreq, mack;
  logic [15:0] ea, opnd, maddr, mrdata;
  logic [2:0] bitno;
  int failures = 0;
  int cmp_count = 0;

  always #2 sys_clk_i = ~sys_clk_i;

  ceau_top i_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .req_valid_i(req), .op_i(op),
    .mode_i(mode), .reg_sel_i(rs), .reg_low_byte_i(fl[3]), .store_i(st), .ibyte2_i(b2),
    .ibyte4_i(w2[7:0]), .iword2_i(w2), .bitno_from_reg_i(fl[2]), .bitno_in_byte4_i(fl[1]),
    .bitno_reg_sel_i(b2[2:0]), .small_const_two_i(fl[0]), .pc_i(w2), .mem_rdata_i(mrdata),
    .mem_ack_i(mack), .exe_wr_en_i(wen), .exe_wr_sel_i(wsel), .exe_wr_data_i(wdata),
    .done_o(done), .illegal_o(ill), .ea_o(ea), .ea_is_mem_o(is_mem), .ea_is_branch_o(is_br),
    .word_op_o(wop), .operand_o(opnd), .bitno_o(bitno), .busy_o(busy), .mem_req_o(mreq),
    .mem_addr_o(maddr));
  ceau_mem_model i_mem (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .delay_i(mdelay),
    .mem_req_i(mreq), .mem_addr_i(maddr), .mem_ack_o(mack), .mem_rdata_o(mrdata));

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  task automatic ck(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : ck

  // One request; bytes 3-4 also give byte 4 and the PC, byte 2 the bit-number register
  task automatic iss(input logic xi, input ceau_op_t o, input ceau_mode_t m,
    input logic [2:0] r = 3'h0, input logic s = 1'b0, input logic [7:0] c2 = 8'h00,
    input logic [15:0] c34 = 16'h0000, input logic [3:0] f = 4'h0);
    int n;
    @(posedge sys_clk_i);
    op <= o;
    mode <= m;
    rs <= r;
    st <= s;
    b2 <= c2;
    w2 <= c34;
    fl <= f;
    req <= 1'b1;
    @(posedge sys_clk_i);
    req <= 1'b0;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end while (done !== 1'b1 && n < 40);
    ck("done", 16'h0001, {15'h0000, done});
    ck("illegal", {15'h0000, xi}, {15'h0000, ill});
  endtask : iss

  task automatic wreg(input logic [2:0] r, input logic [15:0] d);
    @(posedge sys_clk_i);
    wen <= 1'b1;
    wsel <= r;
    wdata <= d;
    @(posedge sys_clk_i);
    wen <= 1'b0;
  endtask : wreg

  task automatic rg(input logic [2:0] r, input logic [15:0] e);
    iss(1'b0, WM, CEAU_AM_REG_DIRECT, r);
    ck("register", e, opnd);
  endtask : rg

  task automatic t_direct();
    wreg(3'h3, 16'h12A4);
    iss(1'b0, BM, CEAU_AM_REG_DIRECT, 3'h3, 1'b0, 8'h00, 16'h0000, 4'h8);
    ck("low byte", 16'h00A4, opnd);
    iss(1'b0, BM, CEAU_AM_REG_DIRECT, 3'h3);
    ck("high byte", 16'h0012, opnd);
    ck("byte size", 16'h0000, {15'h0000, wop});
    iss(1'b0, CEAU_OP_WORD_ADD, CEAU_AM_REG_DIRECT, 3'h3);
    ck("word", 16'h12A4, opnd);
    iss(1'b0, CEAU_OP_SUB_SMALL_CONST, CEAU_AM_REG_DIRECT, 3'h3, 1'b0, 8'h00, 16'h0000, 4'h1);
    ck("constant", 16'h0002, opnd);
    iss(1'b0, CEAU_OP_BYTE_ADD, CEAU_AM_IMM8, 3'h0, 1'b0, 8'h5C);
    ck("imm8", 16'h005C, opnd);
    iss(1'b1, CEAU_OP_WORD_ADD, CEAU_AM_IMM8);
    iss(1'b1, CEAU_OP_ALU_OTHER, CEAU_AM_REG_INDIRECT);
    iss(1'b0, WM, CEAU_AM_IMM16, 3'h0, 1'b0, 8'h00, 16'hBEEF);
    iss(1'b1, BM, CEAU_AM_IMM16);
  endtask : t_direct

  task automatic t_indirect();
    wreg(3'h4, 16'h1235);
    iss(1'b0, WM, CEAU_AM_REG_INDIRECT, 3'h4);
    ck("word ea", 16'h1234, ea);
    iss(1'b0, BM, CEAU_AM_REG_INDIRECT, 3'h4);
    ck("byte ea", 16'h1235, ea);
    ck("is mem", 16'h0001, {15'h0000, is_mem});
    iss(1'b0, BM, CEAU_AM_DISP16, 3'h4, 1'b0, 8'h00, 16'hFFFF);
    ck("disp ea", 16'h1234, ea);
    iss(1'b1, CEAU_OP_BYTE_ADD, CEAU_AM_DISP16, 3'h4);
  endtask : t_indirect

  task automatic t_step();
    wreg(3'h2, 16'hFFFF);
    iss(1'b0, BM, CEAU_AM_POST_INC, 3'h2);
    ck("postinc ea", 16'hFFFF, ea);
    rg(3'h2, 16'h0000);
    iss(1'b0, WM, CEAU_AM_POST_INC, 3'h2);
    rg(3'h2, 16'h0002);
    iss(1'b0, WM, CEAU_AM_PRE_DEC, 3'h2, 1'b1);
    ck("predec ea", 16'h0000, ea);
    iss(1'b0, BM, CEAU_AM_PRE_DEC, 3'h2, 1'b1);
    ck("predec ea", 16'hFFFF, ea);
    iss(1'b1, BM, CEAU_AM_POST_INC, 3'h2, 1'b1);
    iss(1'b1, BM, CEAU_AM_PRE_DEC, 3'h2, 1'b0);
    rg(3'h2, 16'hFFFF);
    wreg(3'h7, 16'h0200);
    iss(1'b0, CEAU_OP_PUSH, CEAU_AM_PRE_DEC, 3'h3);
    ck("push ea", 16'h01FE, ea);
    iss(1'b0, CEAU_OP_POP, CEAU_AM_POST_INC, 3'h3);
    ck("pop ea", 16'h01FE, ea);
    rg(3'h7, 16'h0200);
  endtask : t_step

  task automatic t_bits();
    iss(1'b0, BM, CEAU_AM_ABS8, 3'h0, 1'b0, 8'h34);
    iss(1'b1, WM, CEAU_AM_ABS8);
    iss(1'b0, CEAU_OP_BIT_TEST, CEAU_AM_ABS8, 3'h0, 1'b0, 8'h00, 16'h00FE, 4'h2);
    ck("bit byte4", 16'h0006, {13'h0000, bitno});
    iss(1'b0, CEAU_OP_BIT_SET, CEAU_AM_REG_DIRECT, 3'h0, 1'b0, 8'h73);
    ck("bit byte2", 16'h0003, {13'h0000, bitno});
    wreg(3'h5, 16'h00FD);
    iss(1'b0, CEAU_OP_BIT_CLEAR, CEAU_AM_REG_INDIRECT, 3'h5, 1'b0, 8'h02, 16'h0000, 4'h4);
    ck("bit reg", 16'h0007, {13'h0000, bitno});
    ck("bit ea", 16'h00FD, ea);
    iss(1'b1, CEAU_OP_BIT_SET, CEAU_AM_DISP16, 3'h5);
    iss(1'b1, CEAU_OP_BIT_SET, CEAU_AM_ABS16);
    iss(1'b0, CEAU_OP_JUMP, CEAU_AM_ABS16, 3'h0, 1'b0, 8'h00, 16'h4321);
    ck("jump ea", 16'h4320, ea);
  endtask : t_bits

  task automatic t_branch();
    iss(1'b0, CEAU_OP_COND_BRANCH, CEAU_AM_PC_REL, 3'h0, 1'b0, 8'h80, 16'h1000);
    ck("back", 16'h0F80, ea);
    iss(1'b0, CEAU_OP_BRANCH_TO_SUBROUTINE, CEAU_AM_PC_REL, 3'h0, 1'b0, 8'h7E, 16'hFFF0);
    ck("wrap", 16'h006E, ea);
    iss(1'b0, CEAU_OP_JUMP, CEAU_AM_MEM_IND, 3'h0, 1'b0, 8'h41);
    ck("indirect", 16'hBF40, ea);
    ck("is branch", 16'h0001, {15'h0000, is_br});
    @(posedge sys_clk_i);
    mdelay <= 4'h5;
    iss(1'b0, CEAU_OP_SUBROUTINE_CALL, CEAU_AM_MEM_IND, 3'h0, 1'b0, 8'hFF);
    ck("slow indirect", 16'h01FE, ea);
    iss(1'b1, BM, CEAU_AM_MEM_IND, 3'h0, 1'b0, 8'h41);
    iss(1'b1, WM, CEAU_AM_PC_REL);
    iss(1'b1, CEAU_OP_COND_BRANCH, CEAU_AM_MEM_IND);
  endtask : t_branch

  initial begin
    repeat (12) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_direct();
    t_indirect();
    t_step();
    t_bits();
    t_branch();
    test_done();
  end

  // About forty requests of under twenty cycles each
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    failures++;
    test_done();
  end
endmodule : cpu_effective_address_unit_test
